// *** rtl/spbr_defines.svh ***
// offsets, field positions, reset values and timing counts of the strobed byte read block
// assumes a 10 MHz pclk and a 32-bit apb register bus
`ifndef SPBR_DEFINES_SVH
`define SPBR_DEFINES_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define SPBR_OFS_CMD_LO     8'h00
`define SPBR_OFS_CMD_HI     8'h04
`define SPBR_OFS_CTRL       8'h08
`define SPBR_OFS_STATUS     8'h0C
`define SPBR_OFS_RESP_LO    8'h10
`define SPBR_OFS_RESP_HI    8'h14
`define SPBR_OFS_LINE_LEVEL 8'h18
`define SPBR_OFS_LINE_DIR   8'h1C

// ************************************************************
// fields and codes
// ************************************************************
`define SPBR_CODE_STROBED_READ 8'h0C
`define SPBR_PORT_A            8'h00
`define SPBR_PORT_B            8'h01
`define SPBR_CTRL_GO_BIT       0
`define SPBR_CTRL_GAP_LSB      8
`define SPBR_ST_BUSY_BIT       0
`define SPBR_ST_DONE_BIT       1
`define SPBR_ST_ERR_BIT        2
`define SPBR_RST_WORD          32'h0000_0000
`define SPBR_RST_LINES         16'h0000

// ************************************************************
// timing
// ************************************************************
`define SPBR_CLK_NS        100
`define SPBR_STB_MIN_NS    10000
`define SPBR_STB_MAX_NS    200000
`define SPBR_LEN_MAX       255
`define SPBR_GAP_UNIT_NS   1000
`define SPBR_STB_MIN_CYC   ((`SPBR_STB_MIN_NS + `SPBR_CLK_NS - 1) / `SPBR_CLK_NS)
`define SPBR_STB_STEP_CYC  ((`SPBR_STB_MAX_NS - `SPBR_STB_MIN_NS) / `SPBR_LEN_MAX / `SPBR_CLK_NS)
`define SPBR_GAP_UNIT_CYC  (`SPBR_GAP_UNIT_NS / `SPBR_CLK_NS)
`define SPBR_TMR_W         12

`endif

// *** rtl/spbr_pkg.sv ***
// types of the strobed byte read block
// assumes nothing beyond the defines header
package spbr_pkg;

   // ************************************************************
   // sequencer states, gray along idle-drive-sample-restore-gap
   // ************************************************************
   typedef enum logic [2:0] {
      SPBR_IDLE    = 3'b000,
      SPBR_DRIVE   = 3'b001,
      SPBR_SAMPLE  = 3'b011,
      SPBR_RESTORE = 3'b010,
      SPBR_GAP     = 3'b110
   } spbr_state_e;

   // ************************************************************
   // eight byte command frame, byte 0 in the low bits
   // ************************************************************
   typedef struct packed {
      logic [7:0] unused7;
      logic [7:0] unused6;
      logic [7:0] unused5;
      logic [7:0] stretch;
      logic [2:0] sel_rsvd;
      logic       pol_high;
      logic [3:0] line;
      logic [7:0] port;
      logic [7:0] unused1;
      logic [7:0] code;
   } spbr_cmd_s;

   // ************************************************************
   // apb request as seen by the slave
   // ************************************************************
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } spbr_apb_req_s;

endpackage

// *** rtl/spbr_strobed_read.sv ***
// strobed byte read engine with apb registers and two 8-bit ports
// assumes a single pclk domain; port inputs are synchronous to pclk
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "spbr_defines.svh"
`default_nettype none
module spbr_strobed_read (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire spbr_pkg::spbr_apb_req_s apb_req,
   output var  logic [31:0]            prdata,
   output var  logic                   pready,
   output var  logic                   pslverr,
   input  wire logic [7:0]             port_a_in,
   output var  logic [7:0]             port_a_out,
   output var  logic [7:0]             port_a_oe,
   input  wire logic [7:0]             port_b_in,
   output var  logic [7:0]             port_b_out,
   output var  logic [7:0]             port_b_oe
);
   import spbr_pkg::*;

   localparam int TW = `SPBR_TMR_W;

   // ************************************************************
   // state
   // ************************************************************
   spbr_state_e   state;
   spbr_state_e   next_state;
   logic [31:0]   cmd_lo;
   logic [31:0]   next_cmd_lo;
   logic [31:0]   cmd_hi;
   logic [31:0]   next_cmd_hi;
   logic [7:0]    gap_del;
   logic [7:0]    next_gap_del;
   logic          done;
   logic          next_done;
   logic          err;
   logic          next_err;
   logic [7:0]    resp_val;
   logic [7:0]    next_resp_val;
   logic [7:0]    resp_code;
   logic [7:0]    next_resp_code;
   logic [15:0]   line_level;
   logic [15:0]   next_line_level;
   logic [15:0]   line_dir;
   logic [15:0]   next_line_dir;
   logic          strb_on;
   logic          next_strb_on;
   logic [3:0]    strb_line;
   logic [3:0]    next_strb_line;
   logic          strb_pol;
   logic          next_strb_pol;
   logic          strb_port_b;
   logic          next_strb_port_b;
   logic [15:0]   pin_out;
   logic [15:0]   next_pin_out;
   logic [31:0]   next_prdata;
   logic          next_pready;
   logic          next_pslverr;
   logic          tmr_load;
   logic [TW-1:0] tmr_val;
   logic          tmr_expired;
   spbr_cmd_s     cmd;
   logic          wr_acc;
   logic          setup;

   assign cmd    = spbr_cmd_s'({cmd_hi, cmd_lo});
   assign setup  = apb_req.psel && !apb_req.penable;
   assign wr_acc = apb_req.psel && apb_req.penable && pready && apb_req.pwrite;

   // mapped offsets share one decoder for read and write paths
   function automatic logic spbr_mapped(input logic [7:0] a);
      case (a)
         `SPBR_OFS_CMD_LO, `SPBR_OFS_CMD_HI, `SPBR_OFS_CTRL, `SPBR_OFS_STATUS,
         `SPBR_OFS_RESP_LO, `SPBR_OFS_RESP_HI, `SPBR_OFS_LINE_LEVEL,
         `SPBR_OFS_LINE_DIR: spbr_mapped = 1'b1;
         default: spbr_mapped = 1'b0;
      endcase
   endfunction

   spbr_timer #(
      .W (TW)
   ) u_timer (
      .pclk     (pclk),
      .presetn  (presetn),
      .load     (tmr_load),
      .load_val (tmr_val),
      .expired  (tmr_expired)
   );

   // ************************************************************
   // apb slave, one setup cycle then a zero-wait access
   // ************************************************************
   always_comb begin
      next_pready  = setup;
      next_pslverr = setup && !spbr_mapped(apb_req.paddr);
      next_prdata  = prdata;
      if (setup && !apb_req.pwrite) begin
         case (apb_req.paddr)
            `SPBR_OFS_CMD_LO:     next_prdata = cmd_lo;
            `SPBR_OFS_CMD_HI:     next_prdata = cmd_hi;
            `SPBR_OFS_CTRL:       next_prdata = {16'h0000, gap_del, 8'h00};
            `SPBR_OFS_STATUS:     next_prdata = {29'h0000_0000, err, done,
                                                 state != SPBR_IDLE};
            `SPBR_OFS_RESP_LO:    next_prdata = {16'h0000, resp_val, resp_code};
            `SPBR_OFS_RESP_HI:    next_prdata = 32'h0000_0000;
            `SPBR_OFS_LINE_LEVEL: next_prdata = {16'h0000, line_level};
            `SPBR_OFS_LINE_DIR:   next_prdata = {16'h0000, line_dir};
            default:              next_prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= `SPBR_RST_WORD;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // ************************************************************
   // registers and strobe sequencer
   // ************************************************************
   always_comb begin
      next_state       = state;
      next_cmd_lo      = cmd_lo;
      next_cmd_hi      = cmd_hi;
      next_gap_del     = gap_del;
      next_done        = done;
      next_err         = err;
      next_resp_val    = resp_val;
      next_resp_code   = resp_code;
      next_line_level  = line_level;
      next_line_dir    = line_dir;
      next_strb_on     = strb_on;
      next_strb_line   = strb_line;
      next_strb_pol    = strb_pol;
      next_strb_port_b = strb_port_b;
      tmr_load         = 1'b0;
      // 100 cycles plus 7 per stretch step
      tmr_val          = TW'(`SPBR_STB_MIN_CYC) + TW'(cmd.stretch) * TW'(`SPBR_STB_STEP_CYC);

      // status flags clear on a write of one; the hardware set below wins
      if (wr_acc) begin
         case (apb_req.paddr)
            `SPBR_OFS_CMD_LO: begin
               // frame is not changed under a running strobe
               if (state == SPBR_IDLE) begin
                  next_cmd_lo = apb_req.pwdata;
               end
            end
            `SPBR_OFS_CMD_HI: begin
               if (state == SPBR_IDLE) begin
                  next_cmd_hi = apb_req.pwdata;
               end
            end
            `SPBR_OFS_CTRL: begin
               next_gap_del = apb_req.pwdata[`SPBR_CTRL_GAP_LSB +: 8];
            end
            `SPBR_OFS_STATUS: begin
               if (apb_req.pwdata[`SPBR_ST_DONE_BIT]) begin
                  next_done = 1'b0;
               end
               if (apb_req.pwdata[`SPBR_ST_ERR_BIT]) begin
                  next_err = 1'b0;
               end
            end
            // level and direction belong to software
            `SPBR_OFS_LINE_LEVEL: next_line_level = apb_req.pwdata[15:0];
            `SPBR_OFS_LINE_DIR:   next_line_dir = apb_req.pwdata[15:0];
            default: begin
            end
         endcase
      end

      case (state)
         SPBR_IDLE: begin
            // go while busy is ignored because the sequencer is not idle
            if (wr_acc && apb_req.paddr == `SPBR_OFS_CTRL
                && apb_req.pwdata[`SPBR_CTRL_GO_BIT]) begin
               // byte 0 code is checked, and byte 2 port below
               // port byte must be 00h or 01h
               if (cmd.code == `SPBR_CODE_STROBED_READ
                   && (cmd.port == `SPBR_PORT_A || cmd.port == `SPBR_PORT_B)) begin
                  next_strb_line   = cmd.line;
                  next_strb_pol    = cmd.pol_high;
                  next_strb_port_b = cmd.port[0];
                  next_strb_on     = 1'b1;
                  tmr_load         = 1'b1;
                  next_state       = SPBR_DRIVE;
               end else begin
                  next_err = 1'b1;
               end
            end
         end
         SPBR_DRIVE: begin
            if (tmr_expired) begin
               next_state = SPBR_SAMPLE;
            end
         end
         SPBR_SAMPLE: begin
            // sample port while line still active
            next_resp_val = strb_port_b ? port_b_in : port_a_in;
            next_strb_on  = 1'b0;
            next_state    = SPBR_RESTORE;
         end
         SPBR_RESTORE: begin
            // line already back when the answer appears
            next_resp_code = `SPBR_CODE_STROBED_READ;
            next_done      = 1'b1;
            tmr_val        = TW'(gap_del) * TW'(`SPBR_GAP_UNIT_CYC);
            tmr_load       = (gap_del != 8'h00);
            next_state     = (gap_del != 8'h00) ? SPBR_GAP : SPBR_IDLE;
         end
         SPBR_GAP: begin
            if (tmr_expired) begin
               next_state = SPBR_IDLE;
            end
         end
         default: begin
            next_state   = SPBR_IDLE;
            next_strb_on = 1'b0;
         end
      endcase
   end

   // pin levels: software level with the strobed line overridden
   always_comb begin
      next_pin_out = next_line_level;
      if (next_strb_on) begin
         next_pin_out[next_strb_line] = next_strb_pol;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state       <= SPBR_IDLE;
         cmd_lo      <= `SPBR_RST_WORD;
         cmd_hi      <= `SPBR_RST_WORD;
         gap_del     <= 8'h00;
         done        <= 1'b0;
         err         <= 1'b0;
         resp_val    <= 8'h00;
         resp_code   <= 8'h00;
         line_level  <= `SPBR_RST_LINES;
         line_dir    <= `SPBR_RST_LINES;
         strb_on     <= 1'b0;
         strb_line   <= 4'h0;
         strb_pol    <= 1'b0;
         strb_port_b <= 1'b0;
         pin_out     <= `SPBR_RST_LINES;
         port_a_oe   <= 8'h00;
         port_b_oe   <= 8'h00;
      end else begin
         state       <= next_state;
         cmd_lo      <= next_cmd_lo;
         cmd_hi      <= next_cmd_hi;
         gap_del     <= next_gap_del;
         done        <= next_done;
         err         <= next_err;
         resp_val    <= next_resp_val;
         resp_code   <= next_resp_code;
         line_level  <= next_line_level;
         line_dir    <= next_line_dir;
         strb_on     <= next_strb_on;
         strb_line   <= next_strb_line;
         strb_pol    <= next_strb_pol;
         strb_port_b <= next_strb_port_b;
         pin_out     <= next_pin_out;
         port_a_oe   <= next_line_dir[7:0];
         port_b_oe   <= next_line_dir[15:8];
      end
   end

   // positive strobe relies on software low preset
   assign port_a_out = pin_out[7:0];
   assign port_b_out = pin_out[15:8];
endmodule
`default_nettype wire

// *** rtl/spbr_timer.sv ***
// down counter that flags the last cycle of a loaded interval
// assumes load_val is at least one
`timescale 1ns/1ps
`default_nettype none
module spbr_timer #(
   parameter int W = 12
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   output var  logic         expired
);
   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic         next_expired;

   always_comb begin
      next_cnt     = cnt;
      next_expired = 1'b0;
      if (load) begin
         next_cnt = load_val;
      end else if (cnt != '0) begin
         next_cnt     = cnt - 1'b1;
         next_expired = (cnt == {{(W-1){1'b0}}, 1'b1});
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt     <= '0;
         expired <= 1'b0;
      end else begin
         cnt     <= next_cnt;
         expired <= next_expired;
      end
   end
endmodule
`default_nettype wire

// *** test/spbr_periph.sv ***
// far side peripheral: puts a byte on the port while strobed
// assumes the bench sets line, polarity, port and byte before each read
`timescale 1ns/1ps
`default_nettype none
module spbr_periph (
   input  wire logic        pclk,
   input  wire logic [3:0]  line,
   input  wire logic        pol,
   input  wire logic        port,
   input  wire logic [7:0]  data,
   input  wire logic [5:0]  lat,
   input  wire logic [15:0] outs,
   input  wire logic [15:0] oes,
   output var  logic [15:0] pins
);
   logic [5:0] act = 6'h00;
   logic [7:0] drv = 8'hA5;
   // byte follows strobe after lat cycles
   always @(posedge pclk) begin
      act <= (oes[line] && outs[line] == pol) ? ((act == lat) ? act : act + 6'h01) : 6'h00;
      drv <= (act == lat && oes[line] && outs[line] == pol) ? data : ~drv;
   end
   // released port keeps changing, never a stale byte
   assign pins = (oes & outs) | (~oes & (port ? {drv, ~drv} : {~drv, drv}));
endmodule
`default_nettype wire

// *** test/spbr_props.sv ***
// assertions on the apb and port pins of the strobed read block
// assumes it is bound to spbr_strobed_read
`timescale 1ns/1ps
`default_nettype none
module spbr_props (
   input wire logic                    pclk,
   input wire logic                    presetn,
   input wire spbr_pkg::spbr_apb_req_s apb_req,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   input wire logic [7:0]              port_a_in,
   input wire logic [7:0]              port_a_out,
   input wire logic [7:0]              port_a_oe,
   input wire logic [7:0]              port_b_in,
   input wire logic [7:0]              port_b_out,
   input wire logic [7:0]              port_b_oe
);
   import spbr_pkg::*;
   logic        setup;
   logic        wr;
   logic        pin_wr;
   logic [15:0] outs;
   logic [15:0] oes;
   logic [15:0] outs_q;
   logic [15:0] prev_q;
   logic [11:0] cnt;
   logic [11:0] next_cnt;
   logic [15:0] next_prev;
   assign setup  = apb_req.psel && !apb_req.penable;
   assign wr     = apb_req.psel && apb_req.penable && pready && apb_req.pwrite;
   // level and go writes move pins legally
   assign pin_wr = wr && (apb_req.paddr == 8'h18 || apb_req.paddr == 8'h08);
   assign outs   = {port_b_out, port_a_out};
   assign oes    = {port_b_oe, port_a_oe};
   // *****
   // cycles since pins last moved
   // *****
   always_comb begin
      next_cnt  = (outs != outs_q) ? 12'h000 : ((cnt == 12'hFFF) ? cnt : cnt + 12'h001);
      next_prev = (outs != outs_q) ? outs_q : prev_q;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt    <= 12'h000;
         outs_q <= 16'h0000;
         prev_q <= 16'h0000;
      end else begin
         cnt    <= next_cnt;
         outs_q <= outs;
         prev_q <= next_prev;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ready_after_setup: assert property (setup |=> pready)
      else $error("no ready after setup");
   chk_ready_single: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_unmapped_err: assert property (setup && apb_req.paddr >= 8'h20 |=> pslverr && (apb_req.pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   chk_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_dir_write: assert property (wr && apb_req.paddr == 8'h1C |=> oes == $past(apb_req.pwdata[15:0]))
      else $error("direction not taken");
   chk_dir_held: assert property ($changed(oes) |-> $past(wr && apb_req.paddr == 8'h1C))
      else $error("direction moved by itself");
   chk_strobe_min: assert property (outs != outs_q && !$past(pin_wr) |-> cnt >= 12'h063)
      else $error("strobe too short");
   chk_strobe_restore: assert property (outs != outs_q && !$past(pin_wr) |-> outs == prev_q && $onehot(outs ^ outs_q))
      else $error("strobe line not restored alone");
   cover property (setup && apb_req.paddr >= 8'h20);
   cover property (outs != outs_q && !$past(pin_wr));
   cover property (wr && apb_req.paddr == 8'h1C);
endmodule
`default_nettype wire

// *** test/tb_spbr_strobed_read.sv ***
// self-checking bench for the strobed byte read block
// assumes design, checker and peripheral model compile first
`timescale 1ns/1ps
`default_nettype none
module tb_spbr_strobed_read;
   import spbr_pkg::*;
   logic          pclk;
   logic          presetn;
   spbr_apb_req_s req;
   logic [31:0]   prdata;
   logic          pready;
   logic          pslverr;
   logic [7:0]    pa_out, pa_oe, pb_out, pb_oe;
   logic [15:0]   pins;
   logic [3:0]    p_line;
   logic          p_pol, p_port;
   logic [7:0]    p_data;
   logic [5:0]    p_lat;
   logic [31:0]   q;
   logic          e;
   logic [31:0]   exp_q[$];
   int            num_errors, samples_checked;
   int            act_cyc = 0;
   int            cyc = 0;
   spbr_strobed_read spbr_strobed_read_i (.pclk(pclk), .presetn(presetn), .apb_req(req),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_a_in(pins[7:0]),
      .port_a_out(pa_out), .port_a_oe(pa_oe), .port_b_in(pins[15:8]),
      .port_b_out(pb_out), .port_b_oe(pb_oe));
   spbr_periph spbr_periph_i (.pclk(pclk), .line(p_line), .pol(p_pol), .port(p_port),
      .data(p_data), .lat(p_lat), .outs({pb_out, pa_out}), .oes({pb_oe, pa_oe}), .pins(pins));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (pins[p_line] === p_pol) act_cyc <= act_cyc + 1;
   end
   // *****
   // tasks
   // *****
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_len(input int got, input int lo, input int hi);
      samples_checked++;
      if (got < lo || got > hi) begin
         num_errors++;
         $display("mismatch at %0t got %h expected %h", $time, got, lo);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         num_errors++;
         report_and_stop();
      end
      q = prdata;
      e = pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic poll(input int b, input logic v);
      int n;
      n = 0;
      do begin
         apb(1'b0, 8'h0C, 32'h0);
         n++;
      end while (q[b] !== v && n < 2000);
      if (n >= 2000) begin
         num_errors++;
         report_and_stop();
      end
   endtask
   task automatic strobe_read(input logic [3:0] ln, input logic pl, input logic pt,
                              input logic [7:0] len, input logic [7:0] gap, input logic poke);
      int         base;
      int         g0;
      logic [31:0] lo;
      logic [7:0] d8;
      logic [7:0] val;
      logic [15:0] bit1;
      bit1 = 16'h0001 << ln;
      d8   = 8'($urandom);
      val  = d8;
      if (ln[3] == pt) val[ln[2:0]] = pl;
      exp_q.push_back({16'h0, val, 8'h0C});
      p_line <= ln;
      p_pol  <= pl;
      p_port <= pt;
      p_data <= d8;
      p_lat  <= 6'($urandom_range(40));
      // line made an output first, then its level set to idle
      apb(1'b1, 8'h1C, {16'h0, bit1});
      apb(1'b1, 8'h18, {16'h0, pl ? 16'h0 : bit1});
      lo = {3'($urandom), pl, ln, 7'h00, pt, 8'($urandom), 8'h0C};
      apb(1'b1, 8'h00, lo);
      apb(1'b1, 8'h04, {24'($urandom), len});
      base = act_cyc;
      apb(1'b1, 8'h08, {16'h0, gap, 8'h01});
      if (poke) begin
         // frame and go refused while busy
         apb(1'b1, 8'h00, 32'h0000_010B);
         apb(1'b1, 8'h08, 32'h0000_0001);
         apb(1'b0, 8'h0C, 32'h0);
         chk(q & 32'h7, 32'h1);
         apb(1'b0, 8'h00, 32'h0);
         chk(q, lo);
      end
      poll(1, 1'b1);
      g0 = cyc;
      if (gap == 8'hFF) chk(q & 32'h7, 32'h3);
      chk({31'h0, pins[ln]}, {31'h0, ~pl});
      chk_len(act_cyc - base, 100 + 7 * len, 103 + 7 * len);
      apb(1'b0, 8'h10, 32'h0);
      chk(q, exp_q.pop_front());
      apb(1'b0, 8'h14, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      chk(q, {16'h0, gap, 8'h00});
      apb(1'b1, 8'h0C, 32'h0000_0002);
      poll(0, 1'b0);
      chk(q & 32'h7, 32'h0);
      chk_len(cyc - g0, 10 * int'(gap) - 5, 10 * int'(gap) + 20);
   endtask
   // *****
   // main sequence
   // *****
   initial begin
      num_errors = 0;
      samples_checked = 0;
      req = '0;
      presetn = 1'b0;
      {p_line, p_pol, p_port, p_data, p_lat} = '0;
      q = $urandom(32'h237A);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b1, 8'h10, 32'hFFFF_FFFF);
      apb(1'b1, 8'h20, 32'hFFFF_FFFF);
      for (int a = 0; a < 40; a += 4) begin
         apb(1'b0, 8'(a), 32'h0);
         chk(q, 32'h0);
         chk({31'h0, e}, {31'h0, a >= 32});
      end
      chk({pb_oe, pa_oe, pb_out, pa_out}, 32'h0);
      $display("reset test done");
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, 8'h00, i ? 32'h0002_000C : 32'h0000_000B);
         apb(1'b1, 8'h08, 32'h0000_0001);
         apb(1'b0, 8'h0C, 32'h0);
         chk(q & 32'h7, 32'h4);
         apb(1'b1, 8'h0C, 32'h0000_0004);
         apb(1'b0, 8'h0C, 32'h0);
         chk(q & 32'h7, 32'h0);
      end
      $display("bad frame test done");
      for (int i = 0; i < 16; i++)
         strobe_read(4'(i), i[0], 1'($urandom), (i == 15) ? 8'hFF : 8'($urandom_range(20)),
                     (i == 15) ? 8'hFF : 8'h00, i == 5);
      $display("strobe test done");
      report_and_stop();
   end
endmodule
bind spbr_strobed_read spbr_props spbr_props_i (.pclk(pclk), .presetn(presetn),
   .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .port_a_in(port_a_in), .port_a_out(port_a_out), .port_a_oe(port_a_oe),
   .port_b_in(port_b_in), .port_b_out(port_b_out), .port_b_oe(port_b_oe));
`default_nettype wire
